// *** status_pkg.sv ***
// Shared constants for the status register sets
package status_pkg;

    // Register data width and the writable value mask
    localparam int DATA_W = 16;
    localparam logic [15:0] VALUE_MASK = 16'h7FFF;

    // Register set selectors on the command port
    localparam logic [1:0] SET_DEVICE = 2'h0;
    localparam logic [1:0] SET_OPERATION = 2'h1;
    localparam logic [1:0] SET_CALIBRATING = 2'h2;

    // Register selectors inside a set
    localparam logic [2:0] REG_CONDITION = 3'h0;
    localparam logic [2:0] REG_EVENT = 3'h1;
    localparam logic [2:0] REG_ENABLE = 3'h2;
    localparam logic [2:0] REG_FALL_FILTER = 3'h3;
    localparam logic [2:0] REG_RISE_FILTER = 3'h4;

    // Bits in use in each set
    localparam logic [15:0] DEVICE_USED = 16'h407E;
    localparam logic [15:0] OPERATION_USED = 16'h1C31;
    localparam logic [15:0] CALIBRATING_USED = 16'h0006;

    // Device-status bit positions (channel B is one above channel A)
    localparam int DEV_PRESENT_A = 1;
    localparam int DEV_FAULT_A = 3;
    localparam int DEV_REAR_A = 5;
    localparam int DEV_KEY_PRESS = 14;

    // Operation bit positions
    localparam int OPER_CALIBRATING = 0;
    localparam int OPER_MEASURING = 4;
    localparam int OPER_TRIGGER_WAIT = 5;
    localparam int OPER_SENSOR_READ = 10;
    localparam int OPER_LOW_BOUND_FAIL = 11;
    localparam int OPER_HIGH_BOUND_FAIL = 12;

    // Calibrating-set bit position of channel A
    localparam int CAL_CHANNEL_A = 1;

    // Preset values of enables and filters
    localparam logic [15:0] OPER_ENABLE_PRESET = 16'h0000;
    localparam logic [15:0] OTHER_ENABLE_PRESET = 16'hFFFF;
    localparam logic [15:0] RISE_FILTER_PRESET = 16'hFFFF;
    localparam logic [15:0] FALL_FILTER_PRESET = 16'h0000;

endpackage : status_pkg

// *** pin_sync.sv ***
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps
module pin_sync
    import status_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Pins and their synchronised copy
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync_out
);

    logic [WIDTH-1:0] stage1_reg; // Only read by the second stage

    // Both stages clear on reset; the second is the only reader of the first
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            stage1_reg <= '0;
            pin_sync_out <= '0;
        end
        else
        begin
            stage1_reg <= pin_in;
            pin_sync_out <= stage1_reg;
        end
    end

endmodule : pin_sync

// *** status_reg_set.sv ***
// One status register set: condition, filters, event latch and enable mask
`timescale 1ns/10ps
module status_reg_set
    import status_pkg::*;
#(
    parameter logic [15:0] USED_MASK = 16'h7FFF,
    parameter logic [15:0] ENABLE_PRESET = 16'hFFFF
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    input wire logic preset,
    // Live condition and unfiltered event sources
    input wire logic [15:0] cond_in,
    input wire logic [15:0] force_event,
    // Write and read-clear requests
    input wire logic write_en,
    input wire logic [2:0] write_reg,
    input wire logic [15:0] write_data,
    input wire logic event_read,
    // Register contents
    output logic [15:0] cond_reg,
    output logic [15:0] event_reg,
    output logic [15:0] enable_reg,
    output logic [15:0] fall_reg,
    output logic [15:0] rise_reg,
    output logic summary
);

    localparam logic [15:0] KEEP = USED_MASK & VALUE_MASK; // Bit 15 never stored

    logic [15:0] cond_now; // Masked live condition
    logic [15:0] event_set; // Bits to latch this cycle
    logic [15:0] event_next;
    logic [15:0] wdata_kept;

    assign cond_now = cond_in & KEEP;
    assign wdata_kept = write_data & KEEP;
    // Filtered edges plus sources that ignore the filters
    assign event_set = ((cond_now & ~cond_reg & rise_reg) | (~cond_now & cond_reg & fall_reg)
                       | force_event) & KEEP;
    // A new event beats the clear of the same read
    assign event_next = (event_read ? 16'h0000 : event_reg) | event_set;
    assign summary = |(event_reg & enable_reg);

    // Condition history and event latch; power-on clears events
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cond_reg <= 16'h0000;
            event_reg <= 16'h0000;
        end
        else
        begin
            cond_reg <= cond_now;
            event_reg <= event_next;
        end
    end

    // Enable and filters; preset leaves the event latch alone
    always_ff @(posedge clk)
    begin
        if (srst || preset)
        begin
            enable_reg <= ENABLE_PRESET & KEEP;
            rise_reg <= RISE_FILTER_PRESET & KEEP;
            fall_reg <= FALL_FILTER_PRESET & KEEP;
        end
        else if (write_en)
        begin
            if (write_reg == REG_ENABLE)
                enable_reg <= wdata_kept;
            if (write_reg == REG_FALL_FILTER)
                fall_reg <= wdata_kept;
            if (write_reg == REG_RISE_FILTER)
                rise_reg <= wdata_kept;
        end
    end

endmodule : status_reg_set

// *** status_sets_top.sv ***
// Status reporting: device, operation and calibrating register sets behind a command port
//
// Overview of operation
// - Event read returns latch, then clears it.
// - Enable write keeps low 15 bits only; code keeps only the set's used bits.
// - Enable read returns stored value unchanged.
// - Falling filter write keeps low 15 bits; code keeps only the set's used bits.
// - Rising filter write keeps low 15 bits; code keeps only the set's used bits.
// - Filter reads return stored 15-bit value.
// - Device bits: present 1-2, fault 3-4, rear 5-6.
// - Present bit high while sensor attached.
// - Falling filter latches event on removal.
// - Rising filter latches event on attachment.
// - Fault on memory failure or both connectors.
// - Location bit high for rear connector.
// - Key press latches event bit 14.
// - Key event ignores filters; condition reads 0.
// - Operation summary bit positions as listed.
// - Bit 15 of sets always zero.
// - Calibrating bits 1 and 2, others unused.
// - Calibrating bit sets when zeroing/calibration begins.
// - Calibrating bit clears when activity finishes.
// - Full calibrate query also sets bit.
// - Condition read returns bits, no change.
// - Preset loads enables and filters per set.
`timescale 1ns/10ps
module status_sets_top
    import status_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Command port from the command parser
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [1:0] cmd_set,
    input wire logic [2:0] cmd_reg,
    input wire logic [15:0] cmd_data,
    input wire logic preset_req,
    // Query answers
    output logic reply_valid,
    output logic [15:0] reply_data,
    // Sensor connector pins, index 0 is channel A
    input wire logic [1:0] front_attached,
    input wire logic [1:0] rear_attached,
    input wire logic [1:0] eeprom_fail,
    input wire logic key_press,
    // Calibration activity strobes from the measurement logic
    input wire logic [1:0] zero_start,
    input wire logic [1:0] cal_start,
    input wire logic [1:0] cal_all_start,
    input wire logic [1:0] cal_finish,
    // Operation summaries of child sets held elsewhere
    input wire logic measuring_sum,
    input wire logic trigger_wait_sum,
    input wire logic sensor_read_sum,
    input wire logic low_bound_fail,
    input wire logic high_bound_fail,
    // Per-channel calibrating flags
    output logic [1:0] calibrating
);

    // Decodes a command aimed at one set
    function automatic logic set_hit
    (
        input logic valid,
        input logic [1:0] set,
        input logic [1:0] want
    );
        set_hit = valid && (set == want);
    endfunction : set_hit

    // Synchronised pins
    logic [1:0] front_sync; // Front connector occupied
    logic [1:0] rear_sync; // Rear connector occupied
    logic [1:0] eeprom_sync; // Sensor memory failed
    logic key_sync; // Key level after the synchroniser
    logic key_seen_reg; // Delayed key level for edge detect
    logic key_pulse; // One cycle per key press

    // Per-set condition vectors
    logic [15:0] dev_cond;
    logic [15:0] oper_cond;
    logic [15:0] cal_cond;
    logic [15:0] dev_force;

    // Per-channel derived sensor state
    logic [1:0] present;
    logic [1:0] fault;
    logic [1:0] at_rear;

    // Calibrating flags
    logic [1:0] cal_begin;
    logic [1:0] calibrating_next;

    // Command decode
    logic hit_dev;
    logic hit_oper;
    logic hit_cal;
    logic do_write;
    logic do_read;
    logic event_query;

    // Device set outputs
    logic [15:0] dev_c; // Condition history
    logic [15:0] dev_e; // Event latch
    logic [15:0] dev_en; // Enable mask
    logic [15:0] dev_f; // Falling filter
    logic [15:0] dev_r; // Rising filter
    logic dev_summary; // No parent set here
    // Operation set outputs
    logic [15:0] oper_c;
    logic [15:0] oper_e;
    logic [15:0] oper_en;
    logic [15:0] oper_f;
    logic [15:0] oper_r;
    logic oper_summary; // Top of the tree
    // Calibrating set outputs
    logic [15:0] cal_c;
    logic [15:0] cal_e;
    logic [15:0] cal_en;
    logic [15:0] cal_f;
    logic [15:0] cal_r;
    logic cal_summary; // Feeds operation bit 0

    // Read path, one word per register kind
    logic [15:0] sel_c;
    logic [15:0] sel_e;
    logic [15:0] sel_en;
    logic [15:0] sel_f;
    logic [15:0] sel_r;
    logic [15:0] read_value;

    // Connector pins come from another domain, so they pass two flops first
    pin_sync #(.WIDTH(7)) u_pin_sync
    (
        .clk(clk),
        .srst(srst),
        .pin_in({key_press, eeprom_fail, rear_attached, front_attached}),
        .pin_sync_out({key_sync, eeprom_sync, rear_sync, front_sync})
    );

    // Key press edge; the delayed copy reads only the synchronised level
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            key_seen_reg <= 1'b0;
        end
        else
        begin
            key_seen_reg <= key_sync;
        end
    end

    assign key_pulse = key_sync & ~key_seen_reg;

    // Derived sensor state per channel
    assign present = front_sync | rear_sync;
    // Both connectors in use is treated as a fault on that channel
    assign fault = eeprom_sync | (front_sync & rear_sync);
    // Location bit means rear; front or no sensor reads zero
    assign at_rear = rear_sync;

    // Device condition vector; key bit is never a condition
    always_comb
    begin
        dev_cond = 16'h0000;
        dev_cond[DEV_PRESENT_A +: 2] = present;
        dev_cond[DEV_FAULT_A +: 2] = fault;
        dev_cond[DEV_REAR_A +: 2] = at_rear;
        dev_cond[DEV_KEY_PRESS] = 1'b0;
    end

    // Key press goes straight into the latch, bypassing the filters
    always_comb
    begin
        dev_force = 16'h0000;
        dev_force[DEV_KEY_PRESS] = key_pulse;
    end

    // Any of the three starts opens a calibrating window
    assign cal_begin = zero_start | cal_start | cal_all_start;
    // A start in the same cycle as a finish keeps the flag set
    assign calibrating_next = (calibrating & ~cal_finish) | cal_begin;

    // Calibrating flags, cleared at power-on
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            calibrating <= 2'b00;
        end
        else
        begin
            calibrating <= calibrating_next;
        end
    end

    // Calibrating condition vector
    always_comb
    begin
        cal_cond = 16'h0000;
        cal_cond[CAL_CHANNEL_A +: 2] = calibrating;
    end

    // Operation condition vector built from child summaries
    always_comb
    begin
        oper_cond = 16'h0000;
        oper_cond[OPER_CALIBRATING] = cal_summary;
        oper_cond[OPER_MEASURING] = measuring_sum;
        oper_cond[OPER_TRIGGER_WAIT] = trigger_wait_sum;
        oper_cond[OPER_SENSOR_READ] = sensor_read_sum;
        oper_cond[OPER_LOW_BOUND_FAIL] = low_bound_fail;
        oper_cond[OPER_HIGH_BOUND_FAIL] = high_bound_fail;
    end

    // Command decode; host values are taken as already rounded integers
    assign hit_dev = set_hit(cmd_valid, cmd_set, SET_DEVICE);
    assign hit_oper = set_hit(cmd_valid, cmd_set, SET_OPERATION);
    assign hit_cal = set_hit(cmd_valid, cmd_set, SET_CALIBRATING);
    assign do_write = cmd_valid && cmd_write;
    assign do_read = cmd_valid && !cmd_write;
    assign event_query = do_read && (cmd_reg == REG_EVENT);

    // Device set
    status_reg_set
    #(
        .USED_MASK(DEVICE_USED),
        .ENABLE_PRESET(OTHER_ENABLE_PRESET)
    )
    u_dev_set
    (
        .clk(clk),
        .srst(srst),
        .preset(preset_req),
        .cond_in(dev_cond),
        .force_event(dev_force),
        .write_en(hit_dev && do_write),
        .write_reg(cmd_reg),
        .write_data(cmd_data),
        .event_read(hit_dev && event_query),
        .cond_reg(dev_c),
        .event_reg(dev_e),
        .enable_reg(dev_en),
        .fall_reg(dev_f),
        .rise_reg(dev_r),
        .summary(dev_summary)
    );

    // Operation set; its enable presets to zeros
    status_reg_set
    #(
        .USED_MASK(OPERATION_USED),
        .ENABLE_PRESET(OPER_ENABLE_PRESET)
    )
    u_oper_set
    (
        .clk(clk),
        .srst(srst),
        .preset(preset_req),
        .cond_in(oper_cond),
        .force_event(16'h0000),
        .write_en(hit_oper && do_write),
        .write_reg(cmd_reg),
        .write_data(cmd_data),
        .event_read(hit_oper && event_query),
        .cond_reg(oper_c),
        .event_reg(oper_e),
        .enable_reg(oper_en),
        .fall_reg(oper_f),
        .rise_reg(oper_r),
        .summary(oper_summary)
    );

    // Calibrating set, summarised into the operation set
    status_reg_set
    #(
        .USED_MASK(CALIBRATING_USED),
        .ENABLE_PRESET(OTHER_ENABLE_PRESET)
    )
    u_cal_set
    (
        .clk(clk),
        .srst(srst),
        .preset(preset_req),
        .cond_in(cal_cond),
        .force_event(16'h0000),
        .write_en(hit_cal && do_write),
        .write_reg(cmd_reg),
        .write_data(cmd_data),
        .event_read(hit_cal && event_query),
        .cond_reg(cal_c),
        .event_reg(cal_e),
        .enable_reg(cal_en),
        .fall_reg(cal_f),
        .rise_reg(cal_r),
        .summary(cal_summary)
    );

    // Set selection; an unknown set reads all zeros
    assign sel_c = hit_dev ? dev_c : hit_oper ? oper_c : hit_cal ? cal_c : 16'h0000;
    assign sel_e = hit_dev ? dev_e : hit_oper ? oper_e : hit_cal ? cal_e : 16'h0000;
    assign sel_en = hit_dev ? dev_en : hit_oper ? oper_en : hit_cal ? cal_en : 16'h0000;
    assign sel_f = hit_dev ? dev_f : hit_oper ? oper_f : hit_cal ? cal_f : 16'h0000;
    assign sel_r = hit_dev ? dev_r : hit_oper ? oper_r : hit_cal ? cal_r : 16'h0000;

    // Register selection within the set
    always_comb
    begin
        case (cmd_reg)
            REG_CONDITION: read_value = sel_c;
            REG_EVENT: read_value = sel_e;
            REG_ENABLE: read_value = sel_en;
            REG_FALL_FILTER: read_value = sel_f;
            REG_RISE_FILTER: read_value = sel_r;
            default: read_value = 16'h0000;
        endcase
    end

    // Answer one cycle after a query; the event value is the one before the clear
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            reply_valid <= 1'b0;
            reply_data <= 16'h0000;
        end
        else
        begin
            reply_valid <= do_read;
            if (do_read)
                reply_data <= read_value & VALUE_MASK;
        end
    end

    // The device summary has no parent here; the operation summary is left unused as well
    logic unused_summary;
    assign unused_summary = dev_summary ^ oper_summary;

endmodule : status_sets_top

// *** status_sets_chk.sv ***
// Port-level assertions for the status register sets
`timescale 1ns/10ps
module status_sets_chk
    import status_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Command port
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [1:0] cmd_set,
    input wire logic [2:0] cmd_reg,
    input wire logic [15:0] cmd_data,
    input wire logic preset_req,
    input wire logic reply_valid,
    input wire logic [15:0] reply_data,
    // Pins and strobes
    input wire logic [1:0] front_attached,
    input wire logic [1:0] rear_attached,
    input wire logic [1:0] eeprom_fail,
    input wire logic key_press,
    input wire logic [1:0] zero_start,
    input wire logic [1:0] cal_start,
    input wire logic [1:0] cal_all_start,
    input wire logic [1:0] cal_finish,
    input wire logic measuring_sum,
    input wire logic trigger_wait_sum,
    input wire logic sensor_read_sum,
    input wire logic low_bound_fail,
    input wire logic high_bound_fail,
    input wire logic [1:0] calibrating
);
    // Any start per channel; a finish only counts when no start competes
    wire logic [1:0] start_any = zero_start | cal_start | cal_all_start;
    wire logic [1:0] finish_only = cal_finish & ~start_any;
    wire logic query = cmd_valid & ~cmd_write;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_reply_after_query:
        assert property (query |=> reply_valid) else $error("query got no answer");
    a_no_stray_reply:
        assert property (!query |=> !reply_valid) else $error("answer without query");
    a_reply_top_zero:
        assert property (reply_valid |-> !reply_data[15]) else $error("answer bit 15 set");
    a_reply_holds_value:
        assert property (!reply_valid && !$past(srst) |-> $stable(reply_data)) else $error("answer moved");
    a_cal_start_sets:
        assert property (start_any != 2'b00 |=> (calibrating & $past(start_any)) == $past(start_any))
        else $error("calibrating flag not set");
    a_cal_finish_clears:
        assert property (finish_only != 2'b00 |=> (calibrating & $past(finish_only)) == 2'b00)
        else $error("calibrating flag not cleared");
    a_cal_idle_holds:
        assert property ((start_any | cal_finish) == 2'b00 |=> $stable(calibrating)) else $error("flag moved");
    a_unmapped_reads_zero:
        assert property (query && (cmd_set == 2'h3 || cmd_reg > 3'h4) |=> reply_data == 16'h0000)
        else $error("unmapped read not zero");
    a_cal_unused_zero:
        assert property (query && cmd_set == SET_CALIBRATING |=> (reply_data & ~CALIBRATING_USED) == 16'h0000)
        else $error("unused calibrating bit set");
    a_key_cond_zero:
        assert property (query && cmd_set == SET_DEVICE && cmd_reg == REG_CONDITION |=> !reply_data[14])
        else $error("key condition bit set");
    // Main scenarios reached
    c_cal_query: cover property (query && cmd_set == SET_CALIBRATING);
    c_cal_start: cover property (start_any != 2'b00);
    c_cal_finish: cover property (finish_only != 2'b00);
endmodule : status_sets_chk

bind status_sets_top status_sets_chk chk (.clk, .srst, .cmd_valid, .cmd_write, .cmd_set, .cmd_reg, .cmd_data,
    .preset_req, .reply_valid, .reply_data, .front_attached, .rear_attached, .eeprom_fail, .key_press,
    .zero_start, .cal_start, .cal_all_start, .cal_finish, .measuring_sum, .trigger_wait_sum,
    .sensor_read_sum, .low_bound_fail, .high_bound_fail, .calibrating);

// *** host_model.sv ***
// Host controller model issuing status commands and collecting answers
`timescale 1ns/10ps
module host_model
    import status_pkg::*;
(
    // Clock
    input wire logic clk,
    // Command lines to the block
    output logic cmd_valid,
    output logic cmd_write,
    output logic [1:0] cmd_set,
    output logic [2:0] cmd_reg,
    output logic [15:0] cmd_data,
    // Answers from the block
    input wire logic reply_valid,
    input wire logic [15:0] reply_data
);
    // Idle lines from time zero
    initial
    begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_set = 2'h3;
        cmd_reg = 3'h7;
        cmd_data = 16'h0000;
    end
    // One command; a query waits a bounded time for its answer
    task automatic xfer(input logic wr, input logic [1:0] set, input logic [2:0] rsel,
                        input logic [15:0] data, output logic [15:0] rd);
        int n;
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_set = set;
        cmd_reg = rsel;
        cmd_data = data;
        @(negedge clk);
        cmd_valid = 1'b0;
        // Released data and set lines do not keep their last value
        cmd_data = ~data;
        cmd_set = ~set;
        rd = 'x;
        n = 0;
        while (!wr && reply_valid !== 1'b1 && n < 4)
        begin
            @(negedge clk);
            n++;
        end
        if (!wr && reply_valid === 1'b1)
            rd = reply_data;
    endtask : xfer
endmodule : host_model

// *** scpi_status_register_sets_tb.sv ***
// Self-checking bench for the status register sets
`timescale 1ns/10ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module scpi_status_register_sets_tb
    import status_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic cmd_valid, cmd_write, reply_valid, key_press, preset_req;
    logic [1:0] cmd_set, front_attached, rear_attached, eeprom_fail, calibrating;
    logic [1:0] zero_start, cal_start, cal_all_start, cal_finish;
    logic [2:0] cmd_reg;
    logic [15:0] cmd_data, reply_data;
    logic measuring_sum, trigger_wait_sum, sensor_read_sum, low_bound_fail, high_bound_fail;
    int failures = 0;
    int samples_checked = 0;
    // 50 MHz clock
    always #10 clk = ~clk;
    status_sets_top dut (.clk, .srst, .cmd_valid, .cmd_write, .cmd_set, .cmd_reg, .cmd_data, .preset_req,
        .reply_valid, .reply_data, .front_attached, .rear_attached, .eeprom_fail, .key_press, .zero_start,
        .cal_start, .cal_all_start, .cal_finish, .measuring_sum, .trigger_wait_sum, .sensor_read_sum,
        .low_bound_fail, .high_bound_fail, .calibrating);
    host_model host (.clk, .cmd_valid, .cmd_write, .cmd_set, .cmd_reg, .cmd_data, .reply_valid, .reply_data);
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic wr(input logic [1:0] s, input logic [2:0] r, input logic [15:0] d);
        logic [15:0] unused;
        host.xfer(1'b1, s, r, d, unused);
    endtask : wr
    // Query and compare against the expected word
    task automatic qchk(input logic [1:0] s, input logic [2:0] r, input logic [15:0] e);
        logic [15:0] got;
        host.xfer(1'b0, s, r, 16'h0000, got);
        `CHK(got, e)
    endtask : qchk
    task automatic t_reset_values();
        qchk(SET_DEVICE, REG_ENABLE, 16'h407E);
        qchk(SET_OPERATION, REG_ENABLE, 16'h0000);
        qchk(SET_OPERATION, REG_RISE_FILTER, 16'h1C31);
        qchk(SET_CALIBRATING, REG_RISE_FILTER, 16'h0006);
        qchk(SET_DEVICE, REG_FALL_FILTER, 16'h0000);
    endtask : t_reset_values
    // Bit 15 and unused bits never stored; unmapped places read zero
    task automatic t_masked_writes();
        wr(SET_DEVICE, REG_ENABLE, 16'hFFFF);
        wr(SET_OPERATION, REG_FALL_FILTER, 16'hFFFF);
        wr(SET_DEVICE, REG_RISE_FILTER, 16'h8002);
        qchk(SET_DEVICE, REG_ENABLE, 16'h407E);
        qchk(SET_OPERATION, REG_FALL_FILTER, 16'h1C31);
        qchk(SET_DEVICE, REG_RISE_FILTER, 16'h0002);
        wr(SET_OPERATION, REG_ENABLE, 16'h1010);
        qchk(SET_OPERATION, REG_ENABLE, 16'h1010);
        qchk(2'h3, REG_ENABLE, 16'h0000);
        qchk(SET_DEVICE, 3'h5, 16'h0000);
    endtask : t_masked_writes
    // Attach, mixed connectors, faults, then a filtered removal
    task automatic t_sensors();
        front_attached = 2'b01;
        cyc(6);
        qchk(SET_DEVICE, REG_CONDITION, 16'h0002);
        qchk(SET_DEVICE, REG_EVENT, 16'h0002);
        qchk(SET_DEVICE, REG_EVENT, 16'h0000);
        rear_attached = 2'b11;
        eeprom_fail = 2'b10;
        cyc(6);
        qchk(SET_DEVICE, REG_CONDITION, 16'h007E);
        qchk(SET_DEVICE, REG_EVENT, 16'h0000);
        front_attached = 2'b10;
        rear_attached = 2'b00;
        eeprom_fail = 2'b00;
        cyc(6);
        qchk(SET_DEVICE, REG_CONDITION, 16'h0004);
        wr(SET_DEVICE, REG_FALL_FILTER, 16'h0004);
        qchk(SET_DEVICE, REG_FALL_FILTER, 16'h0004);
        front_attached = 2'b00;
        cyc(6);
        qchk(SET_DEVICE, REG_EVENT, 16'h0004);
    endtask : t_sensors
    // Key press latches although its filter bits are clear
    task automatic t_key();
        key_press = 1'b1;
        cyc(3);
        // Condition looked at while the key is still held
        qchk(SET_DEVICE, REG_CONDITION, 16'h0000);
        key_press = 1'b0;
        cyc(5);
        qchk(SET_DEVICE, REG_EVENT, 16'h4000);
    endtask : t_key
    task automatic t_calibration();
        zero_start = 2'b01;
        cyc(1);
        zero_start = 2'b00;
        `CHK(calibrating, 2'b01)
        cyc(4);
        qchk(SET_CALIBRATING, REG_CONDITION, 16'h0002);
        qchk(SET_OPERATION, REG_CONDITION, 16'h0001);
        cal_finish = 2'b01;
        cal_all_start = 2'b10;
        cyc(1);
        `CHK(calibrating, 2'b10)
        cal_finish = 2'b10;
        cal_all_start = 2'b00;
        cal_start = 2'b01;
        cyc(1);
        `CHK(calibrating, 2'b01)
        cal_start = 2'b00;
        cal_finish = 2'b01;
        cyc(1);
        cal_finish = 2'b00;
        `CHK(calibrating, 2'b00)
    endtask : t_calibration
    task automatic t_operation();
        qchk(SET_CALIBRATING, REG_EVENT, 16'h0006);
        {measuring_sum, trigger_wait_sum, sensor_read_sum, low_bound_fail, high_bound_fail} = 5'h1F;
        cyc(3);
        qchk(SET_OPERATION, REG_CONDITION, 16'h1C30);
        qchk(SET_OPERATION, REG_EVENT, 16'h1C31);
        {measuring_sum, trigger_wait_sum, sensor_read_sum, low_bound_fail, high_bound_fail} = 5'h00;
        cyc(3);
        qchk(SET_OPERATION, REG_EVENT, 16'h1C30);
    endtask : t_operation
    task automatic t_preset();
        wr(SET_DEVICE, REG_ENABLE, 16'h0000);
        preset_req = 1'b1;
        cyc(1);
        preset_req = 1'b0;
        qchk(SET_DEVICE, REG_ENABLE, 16'h407E);
        qchk(SET_OPERATION, REG_FALL_FILTER, 16'h0000);
        qchk(SET_DEVICE, REG_RISE_FILTER, 16'h407E);
    endtask : t_preset
    // Mid-run power-on drops a latched key press and presets the filters
    task automatic t_power_on();
        wr(SET_OPERATION, REG_FALL_FILTER, 16'h0010);
        key_press = 1'b1;
        cyc(4);
        key_press = 1'b0;
        srst = 1'b1;
        cyc(2);
        srst = 1'b0;
        qchk(SET_DEVICE, REG_EVENT, 16'h0000);
        qchk(SET_OPERATION, REG_FALL_FILTER, 16'h0000);
    endtask : t_power_on
    task automatic tally_and_finish();
        if (failures == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    // Main sequence
    initial
    begin
        {front_attached, rear_attached, eeprom_fail, key_press, preset_req} = '0;
        {zero_start, cal_start, cal_all_start, cal_finish} = '0;
        {measuring_sum, trigger_wait_sum, sensor_read_sum, low_bound_fail, high_bound_fail} = '0;
        cyc(8);
        srst = 1'b0;
        t_reset_values();
        t_masked_writes();
        t_sensors();
        t_key();
        t_calibration();
        t_operation();
        t_preset();
        t_power_on();
        tally_and_finish();
    end
    // Watchdog well beyond the 140 or so cycles needed
    initial
    begin
        #100000;
        failures++;
        tally_and_finish();
    end
endmodule : scpi_status_register_sets_tb
